// File: src/seq_cfg_defines.vh
// constants for the cascade sequencing and auxiliary fault routing block
`ifndef SEQ_CFG_DEFINES_VH
`define SEQ_CFG_DEFINES_VH
// ****************************************
// command codes
// ****************************************
`define CMD_OPERATION      8'h01
`define CMD_CLEAR_FAULTS   8'h03
`define CMD_TOFF_DELAY     8'h64
`define CMD_CHAN_CONFIG    8'hd0
`define CMD_OV_OC_SELECT   8'hd4
`define CMD_UC_TRACK_SEL   8'hd5
`define CMD_FL0_RESPONSE   8'hd6
`define CMD_RETRY_LIMIT    8'hd7
`define CMD_STATUS         8'hd8
// ****************************************
// fields and reset values
// ****************************************
`define OPERATION_ON_BIT   7
`define CFG_CASCADE_BIT    14
`define CFG_CTRL_SEL_HI    13
`define CFG_CTRL_SEL_LO    12
`define CFG_RESET          16'h0000
`define OV_OC_RESET        8'h00
`define UC_TRACK_RESET     8'h00
`define TOFF_RESET         16'h0000
`define RETRY_RESET        3'h0
// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS      40
`define TOFF_UNIT_NS       1000
`define TOFF_UNIT_CYCLES   (`TOFF_UNIT_NS / `CLK_PERIOD_NS)
`define RETRY_TIME_NS      20000
`define RETRY_CYCLES       (`RETRY_TIME_NS / `CLK_PERIOD_NS)
`endif

// File: src/chan_seq.v
// per-channel on/off sequencer with retry and latched-off handling
`timescale 1ns/100ps
`default_nettype none
`include "seq_cfg_defines.vh"
module chan_seq (
   // clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // configuration
   input  wire        op_on,
   input  wire        cascade_en,
   input  wire        ctrl_active,
   input  wire        track_en,
   input  wire [15:0] toff_cycles,
   input  wire [2:0]  retry_limit,
   // faults
   input  wire        ov,
   input  wire        oc,
   input  wire        uv,
   input  wire        uc,
   input  wire        fl0_shut,
   // results
   output reg         chan_en,
   output reg         fl0_event,
   output reg         latched
);
   localparam ST_OFF   = 5'h01;
   localparam ST_ON    = 5'h02;
   localparam ST_TOFF  = 5'h04;
   localparam ST_RETRY = 5'h08;
   localparam ST_LATCH = 5'h10;
   localparam [15:0] RETRY_LOAD = `RETRY_CYCLES;

   reg  [4:0]  state;
   reg  [15:0] cnt;
   reg  [2:0]  tries;
   wire        in_toff = state[2];
   wire        fault_now = ov | oc | ((uv | uc) & ~(track_en & in_toff));
   wire        run_req = op_on & ctrl_active;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state     <= ST_OFF;
         cnt       <= 16'h0000;
         tries     <= 3'h0;
         chan_en   <= 1'b0;
         fl0_event <= 1'b0;
         latched   <= 1'b0;
      end else begin
         fl0_event <= 1'b0;
         case (state)
            ST_OFF: begin
               chan_en <= 1'b0;
               if (run_req && !fl0_shut) begin
                  state   <= ST_ON;
                  chan_en <= 1'b1;
                  tries   <= 3'h0;
               end
            end
            ST_ON, ST_TOFF: begin
               if (fault_now) begin
                  chan_en <= 1'b0;
                  cnt     <= RETRY_LOAD;
                  if (tries == retry_limit) begin
                     state   <= ST_LATCH;
                     latched <= 1'b1;
                  end else begin
                     state <= ST_RETRY;
                  end
               end else if (state == ST_ON) begin
                  // timed or immediate off only; a cascade slave ignores its power-good once on
                  if (fl0_shut || !op_on || (!cascade_en && !ctrl_active)) begin
                     fl0_event <= fl0_shut;
                     if (toff_cycles == 16'h0000) begin
                        state   <= ST_OFF;
                        chan_en <= 1'b0;
                     end else begin
                        state <= ST_TOFF;
                        cnt   <= toff_cycles;
                     end
                  end
               end else if (cnt <= 16'h0001) begin
                  state   <= ST_OFF;
                  chan_en <= 1'b0;
               end else begin
                  cnt <= cnt - 16'h0001;
               end
            end
            ST_RETRY: begin
               chan_en <= 1'b0;
               if (!op_on) begin
                  state <= ST_OFF;
               end else if (fl0_shut) begin
                  state     <= ST_OFF;
                  fl0_event <= 1'b1;
               end else if (cnt != 16'h0000) begin
                  cnt <= cnt - 16'h0001;
               end else if (cascade_en || ctrl_active) begin
                  state   <= ST_ON;
                  chan_en <= 1'b1;
                  tries   <= tries + 3'h1;
               end else begin
                  state <= ST_OFF;
               end
            end
            ST_LATCH: begin
               chan_en <= 1'b0;
               if (!op_on) begin
                  state   <= ST_OFF;
                  latched <= 1'b0;
               end
            end
            default: begin
               state   <= ST_OFF;
               chan_en <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// File: src/seq_cfg_top.v
// four-channel cascade sequencer with auxiliary fault pin routing
`timescale 1ns/100ps
`default_nettype none
`include "seq_cfg_defines.vh"
module seq_cfg_top (
   // clock and reset
   input  wire        clk,
   input  wire        arst_n,
   // command port
   input  wire        cmd_wr,
   input  wire        cmd_rd,
   input  wire [7:0]  cmd_code,
   input  wire [1:0]  cmd_page,
   input  wire [15:0] cmd_wdata,
   output reg  [15:0] cmd_rdata,
   output reg         cmd_rvalid,
   // control inputs and shared fault line
   input  wire [3:0]  control_in,
   input  wire        fault_line0_n,
   // per-channel fault detectors
   input  wire [3:0]  ov_fault,
   input  wire [3:0]  oc_fault,
   input  wire [3:0]  uv_fault,
   input  wire [3:0]  uc_fault,
   // supply enables
   output reg  [3:0]  vout_en,
   // auxiliary fault pin, open drain
   input  wire        aux_fault_i,
   output reg         aux_fault_o,
   output reg         aux_fault_oe,
   // host alert
   output reg         host_alert_n
);
   // ****************************************
   // reset release
   // ****************************************
   reg  [1:0] rst_sync;
   wire       rst_n = rst_sync[1];
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end

   // ****************************************
   // configuration registers
   // ****************************************
   reg  [15:0] chan_cfg [0:3];
   reg  [15:0] toff_delay [0:3];
   reg  [3:0]  op_on;
   reg  [3:0]  fault_line0_shutdown_enable;
   reg  [2:0]  retry_limit;
   reg  [7:0]  aux_fault_ov_oc_select;
   reg  [7:0]  aux_fault_uc_track_select;
   reg  [3:0]  fault_line0_input_flag;
   wire [3:0]  fl0_event;
   wire [3:0]  chan_en;
   wire [3:0]  latched;
   wire        wr_clear = cmd_wr && (cmd_code == `CMD_CLEAR_FAULTS);
   integer     i;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < 4; i = i + 1) begin
            chan_cfg[i]   <= `CFG_RESET;
            toff_delay[i] <= `TOFF_RESET;
         end
         op_on                       <= 4'h0;
         fault_line0_shutdown_enable <= 4'h0;
         retry_limit                 <= `RETRY_RESET;
         aux_fault_ov_oc_select      <= `OV_OC_RESET;
         aux_fault_uc_track_select   <= `UC_TRACK_RESET;
      end else if (cmd_wr) begin
         case (cmd_code)
            `CMD_OPERATION: begin
               op_on[cmd_page] <= cmd_wdata[`OPERATION_ON_BIT];
            end
            `CMD_TOFF_DELAY: begin
               toff_delay[cmd_page] <= cmd_wdata;
            end
            `CMD_CHAN_CONFIG: begin
               chan_cfg[cmd_page] <= {1'b0, cmd_wdata[14:0]};
            end
            `CMD_OV_OC_SELECT: begin
               aux_fault_ov_oc_select <= cmd_wdata[7:0];
            end
            `CMD_UC_TRACK_SEL: begin
               aux_fault_uc_track_select <= cmd_wdata[7:0];
            end
            `CMD_FL0_RESPONSE: begin
               fault_line0_shutdown_enable[cmd_page] <= cmd_wdata[0];
            end
            `CMD_RETRY_LIMIT: begin
               retry_limit <= cmd_wdata[2:0];
            end
            default: begin
               retry_limit <= retry_limit;
            end
         endcase
      end
   end

   // ****************************************
   // fault line 0 status and alert
   // ****************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_line0_input_flag <= 4'h0;
         host_alert_n           <= 1'b1;
      end else begin
         fault_line0_input_flag <= fl0_event | (wr_clear ? 4'h0 : fault_line0_input_flag);
         host_alert_n <= ~(|fl0_event | (|fault_line0_input_flag & ~wr_clear));
      end
   end

   // ****************************************
   // channels
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : chan
         wire [1:0]  sel = chan_cfg[g][`CFG_CTRL_SEL_HI:`CFG_CTRL_SEL_LO];
         wire [15:0] toff_cycles;
         wire        ctrl_active = control_in[sel];
         // unit count times cycles per unit, kept to 16 bits
         wire [31:0] toff_full = toff_delay[g] * `TOFF_UNIT_CYCLES;
         assign toff_cycles = (|toff_full[31:16]) ? 16'hffff : toff_full[15:0];
         chan_seq u_seq (
            .clk         (clk),
            .rst_n       (rst_n),
            .op_on       (op_on[g]),
            .cascade_en  (chan_cfg[g][`CFG_CASCADE_BIT]),
            .ctrl_active (ctrl_active),
            .track_en    (aux_fault_uc_track_select[g]),
            .toff_cycles (toff_cycles),
            .retry_limit (retry_limit),
            .ov          (ov_fault[g]),
            .oc          (oc_fault[g]),
            .uv          (uv_fault[g]),
            .uc          (uc_fault[g]),
            .fl0_shut    (~fault_line0_n & fault_line0_shutdown_enable[g]),
            .chan_en     (chan_en[g]),
            .fl0_event   (fl0_event[g]),
            .latched     (latched[g])
         );
      end
   endgenerate

   // ****************************************
   // auxiliary fault pin and enables
   // ****************************************
   // overcurrent, overvoltage and undercurrent routing
   wire [3:0] oc_pull = oc_fault & aux_fault_ov_oc_select[7:4];
   wire [3:0] ov_pull = ov_fault & aux_fault_ov_oc_select[3:0];
   wire [3:0] uc_pull = uc_fault & aux_fault_uc_track_select[7:4];

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aux_fault_o  <= 1'b0;
         aux_fault_oe <= 1'b0;
         vout_en      <= 4'h0;
      end else begin
         // only ever pulls low; release leaves the wire to its pull-up
         aux_fault_o  <= 1'b0;
         aux_fault_oe <= |(oc_pull | ov_pull | uc_pull);
         vout_en      <= chan_en;
      end
   end

   // ****************************************
   // readback
   // ****************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_rdata  <= 16'h0000;
         cmd_rvalid <= 1'b0;
      end else begin
         cmd_rvalid <= cmd_rd;
         if (cmd_rd) begin
            case (cmd_code)
               `CMD_OPERATION:    cmd_rdata <= {8'h00, op_on[cmd_page], 7'h00};
               `CMD_TOFF_DELAY:   cmd_rdata <= toff_delay[cmd_page];
               `CMD_CHAN_CONFIG:  cmd_rdata <= chan_cfg[cmd_page];
               `CMD_OV_OC_SELECT: cmd_rdata <= {8'h00, aux_fault_ov_oc_select};
               `CMD_UC_TRACK_SEL: cmd_rdata <= {8'h00, aux_fault_uc_track_select};
               `CMD_FL0_RESPONSE: cmd_rdata <= {15'h0000, fault_line0_shutdown_enable[cmd_page]};
               `CMD_RETRY_LIMIT:  cmd_rdata <= {13'h0000, retry_limit};
               `CMD_STATUS: begin
                  cmd_rdata <= {3'h0, aux_fault_i, chan_en, latched, fault_line0_input_flag};
               end
               default:           cmd_rdata <= 16'h0000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// File: verif/seq_cfg_sva.sv
// checker for the cascade sequencer and auxiliary fault pin ports
`timescale 1ns/100ps
`default_nettype none
module seq_cfg_sva (
   // clock and reset
   input wire logic        clk,
   input wire logic        arst_n,
   // command port
   input wire logic        cmd_rd,
   input wire logic [15:0] cmd_rdata,
   input wire logic        cmd_rvalid,
   // faults and outputs
   input wire logic [3:0]  ov_fault,
   input wire logic [3:0]  oc_fault,
   input wire logic [3:0]  uc_fault,
   input wire logic [3:0]  vout_en,
   input wire logic        aux_fault_o,
   input wire logic        aux_fault_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire any_fault = |{ov_fault, oc_fault, uc_fault};
   sequence s_rd_answer;
      ##1 cmd_rvalid;
   endsequence
   sequence s_quiet;
      (vout_en == 4'h0 && !aux_fault_oe) [*2];
   endsequence
   a_read_answers: assert property (cmd_rd |-> s_rd_answer) else $error("read got no answer");
   a_rvalid_cause: assert property (cmd_rvalid |-> $past(cmd_rd)) else $error("stray read valid");
   a_rdata_holds: assert property ($changed(cmd_rdata) |-> cmd_rvalid) else $error("read data moved");
   a_aux_drives_low: assert property (aux_fault_oe |-> !aux_fault_o) else $error("aux pin driven high");
   a_aux_needs_fault: assert property (aux_fault_oe |-> $past(any_fault)) else $error("aux pull without fault");
   a_aux_releases: assert property (!any_fault |=> !aux_fault_oe) else $error("aux pull stuck");
   a_ov_drops_chan: assert property (ov_fault[0] && vout_en[0] |-> ##[1:2] !vout_en[0])
      else $error("channel kept on after fault");
   a_reset_quiet: assert property ($rose(arst_n) |-> s_quiet) else $error("outputs active after reset");
endmodule
bind seq_cfg_top seq_cfg_sva chk_u (.clk(clk), .arst_n(arst_n), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
   .cmd_rvalid(cmd_rvalid), .ov_fault(ov_fault), .oc_fault(oc_fault), .uc_fault(uc_fault), .vout_en(vout_en),
   .aux_fault_o(aux_fault_o), .aux_fault_oe(aux_fault_oe));
`default_nettype wire

// File: verif/supply_model.sv
// controlled supplies: power-good after a ramp, and the pulled-up aux pin
`timescale 1ns/100ps
`default_nettype none
module supply_model #(parameter int PG_DLY = 20) (
   // clock
   input wire logic        clk,
   // from the sequencer
   input wire logic [3:0]  vout_en,
   input wire logic        aux_o,
   input wire logic        aux_oe,
   // to the sequencer
   output logic [3:0]      pg,
   output logic            aux_i
);
   int cnt [4];
   // power-good drops on the first clock edge after the enable goes, no hold time
   always @(posedge clk) begin
      for (int i = 0; i < 4; i++) cnt[i] <= vout_en[i] ? ((cnt[i] < PG_DLY) ? cnt[i] + 1 : cnt[i]) : 0;
   end
   always_comb begin
      for (int i = 0; i < 4; i++) pg[i] = (cnt[i] == PG_DLY);
   end
   // open drain with pull-up
   assign aux_i = aux_oe ? aux_o : 1'b1;
endmodule
`default_nettype wire

// File: verif/cascade_seq_aux_fault_track_cfg_bench.sv
// testbench for the cascade sequencer and auxiliary fault routing
`timescale 1ns/100ps
`default_nettype none
`include "seq_cfg_defines.vh"
module cascade_seq_aux_fault_track_cfg_bench;
   logic        clk = 0, arst_n = 0, cmd_wr = 0, cmd_rd = 0, ctrl0 = 0, fl0_n = 1;
   logic [7:0]  cmd_code = 8'h00;
   logic [1:0]  cmd_page = 2'h0;
   logic [15:0] cmd_wdata = 16'h0000;
   logic [3:0]  ov = 4'h0, oc = 4'h0, uv = 4'h0, uc = 4'h0;
   wire  [15:0] cmd_rdata;
   wire  [3:0]  vout_en, pg;
   wire         cmd_rvalid, aux_o, aux_oe, aux_i, host_alert_n;
   int          errors = 0, n_checks = 0;
   seq_cfg_top dut_u (.clk(clk), .arst_n(arst_n), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
      .cmd_page(cmd_page), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
      .control_in({pg[2:0], ctrl0}), .fault_line0_n(fl0_n), .ov_fault(ov), .oc_fault(oc), .uv_fault(uv),
      .uc_fault(uc), .vout_en(vout_en), .aux_fault_i(aux_i), .aux_fault_o(aux_o), .aux_fault_oe(aux_oe),
      .host_alert_n(host_alert_n));
   supply_model sup_u (.clk(clk), .vout_en(vout_en), .aux_o(aux_o), .aux_oe(aux_oe), .pg(pg), .aux_i(aux_i));
   initial forever #20 clk = ~clk;
   // ****************************************
   // shared tasks
   // ****************************************
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] c, input logic [1:0] p, input logic [15:0] d);
      @(negedge clk); cmd_wr = 1; cmd_code = c; cmd_page = p; cmd_wdata = d;
      @(negedge clk); cmd_wr = 0;
   endtask
   task rd(input logic [7:0] c, input logic [1:0] p, output logic [15:0] d);
      @(negedge clk); cmd_rd = 1; cmd_code = c; cmd_page = p;
      // answer stands for one cycle only, so judge it right after the taking edge
      @(posedge clk); #1;
      chk(16'(cmd_rvalid), 16'h0001);
      d = cmd_rdata;
      @(negedge clk); cmd_rd = 0;
   endtask
   // bounded wait, then judge the enable
   task wait_en(input int ch, input logic v);
      int k;
      k = 0;
      while (vout_en[ch] !== v && k < 200) begin
         @(posedge clk); #1; k++;
      end
      chk(16'(vout_en[ch]), 16'(v));
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task t_regs;
      logic [15:0] d;
      rd(8'hd4, 0, d); chk(d, 16'h0000);
      rd(8'hd5, 0, d); chk(d, 16'h0000);
      wr(8'hd4, 0, 16'h00a5); rd(8'hd4, 0, d); chk(d, 16'h00a5);
      rd(8'hee, 0, d); chk(d, 16'h0000);
      wr(8'hd0, 3, 16'hf000); rd(8'hd0, 3, d); chk(d, 16'h7000);
      wr(8'hd4, 0, 16'h0000); wr(8'hd0, 3, 16'h0000);
   endtask
   // each select bit against its own fault kind and channel
   task t_aux;
      logic [7:0] c;
      for (int i = 0; i < 12; i++) begin
         c = (i < 8) ? 8'hd4 : 8'hd5;
         wr(c, 0, 16'h0001 << ((i < 8) ? i : i - 4));
         @(negedge clk);
         if (i < 4) ov = 4'h1 << i; else if (i < 8) oc = 4'h1 << (i - 4); else uc = 4'h1 << (i - 8);
         repeat (2) @(posedge clk); #1;
         chk(16'(aux_oe), 16'h0001);
         chk(16'(aux_i), 16'h0000);
         wr(c, 0, 16'h0000); repeat (2) @(posedge clk); #1;
         chk(16'(aux_oe), 16'h0000);
         @(negedge clk); ov = 4'h0; oc = 4'h0; uc = 4'h0;
      end
   endtask
   // channel 1 is a cascade slave on control input 1, fed by supply 0
   task t_cascade;
      wr(8'hd0, 1, 16'h5000);
      @(negedge clk); ctrl0 = 1;
      wr(8'h01, 1, 16'h0080); wr(8'h01, 0, 16'h0080);
      wait_en(0, 1);
      chk(16'(vout_en[1]), 16'h0000);
      wait_en(1, 1);
      chk(16'(pg[0]), 16'h0001);
   endtask
   task t_fl0;
      logic [15:0] d;
      wr(8'hd6, 1, 16'h0001);
      @(negedge clk); fl0_n = 0;
      wait_en(1, 0);
      repeat (2) @(posedge clk); #1;
      chk(16'(host_alert_n), 16'h0000);
      chk(16'(vout_en[0]), 16'h0001);
      rd(8'hd8, 0, d); chk(16'(d[1]), 16'h0001);
      @(negedge clk); fl0_n = 1;
      wr(8'h03, 0, 16'h0000);
      chk(16'(host_alert_n), 16'h0001);
      rd(8'hd8, 0, d); chk(16'(d[1]), 16'h0000);
   endtask
   // channel 2 turned off with one delay unit, tracked and then untracked
   task t_track;
      wr(8'h64, 2, 16'h0001);
      for (int t = 1; t >= 0; t--) begin
         wr(8'hd5, 0, 16'(t << 2)); wr(8'h01, 2, 16'h0080);
         wait_en(2, 1);
         // host turns off through the off delay
         wr(8'h01, 2, 16'h0000);
         @(posedge clk); @(negedge clk); uv = 4'h4;
         repeat (3) @(posedge clk); #1;
         chk(16'(vout_en[2]), 16'(t));
         repeat (`TOFF_UNIT_CYCLES - 8) @(posedge clk); #1;
         chk(16'(vout_en[2]), 16'(t));
         wait_en(2, 0);
         @(negedge clk); uv = 4'h0;
      end
   endtask
   // slave 1 keeps running and retrying while supply 0 is down
   task t_retry;
      logic [15:0] d;
      wr(8'hd7, 0, 16'h0001);
      @(negedge clk); ctrl0 = 0;
      wait_en(0, 0);
      repeat (4) @(posedge clk); #1;
      chk(16'(pg[0]), 16'h0000);
      chk(16'(vout_en[1]), 16'h0001);
      @(negedge clk); ov = 4'h2;
      wait_en(1, 0);
      @(negedge clk); ov = 4'h0;
      repeat (`RETRY_CYCLES - 10) @(posedge clk); #1;
      chk(16'(vout_en[1]), 16'h0000);
      wait_en(1, 1);
      // second fault uses up the single retry
      @(negedge clk); ov = 4'h2;
      wait_en(1, 0);
      @(negedge clk); ov = 4'h0;
      rd(8'hd8, 0, d); chk(16'(d[5]), 16'h0001);
      wr(8'h01, 1, 16'h0000); wr(8'h01, 1, 16'h0080);
      rd(8'hd8, 0, d); chk(16'(d[5]), 16'h0000);
      chk(16'(vout_en[1]), 16'h0000);
      // fault on the master channel while it is on
      @(negedge clk); ctrl0 = 1;
      wait_en(0, 1);
      @(negedge clk); ov = 4'h1;
      repeat (3) @(posedge clk); #1;
      chk(16'(vout_en[0]), 16'h0000);
      @(negedge clk); ov = 4'h0;
   endtask
   task test_done;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(negedge clk);
      arst_n = 1;
      repeat (3) @(negedge clk);
      t_regs; t_aux; t_cascade; t_fl0; t_track; t_retry;
      test_done;
   end
   // the whole run needs well under a tenth of this
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      test_done;
   end
endmodule
`default_nettype wire
